// ===== rtl/gauge_flags.sv
// state-of-charge flags, condition flags and load model selection
`timescale 1ns/1ps
module gauge_flags
   import gauge_flags_pkg::*;
#(
   parameter int UPDATE_PERIOD = UPDATE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic signed [15:0] remaining_capacity_value,
   input wire logic signed [15:0] average_current_value,
   input wire logic [15:0] voltage_value,
   input wire logic short_detected,
   input wire logic tab_detected,
   input wire logic charge_valid,
   input wire logic signed [15:0] charge_delta,
   output logic initial_charge_warning_flag,
   output logic final_charge_warning_flag,
   output logic internal_short_flag,
   output logic tab_disconnect_flag,
   output logic load_mode_status_bit,
   output logic signed [31:0] load_rate_value,
   output logic irq
);

   function automatic logic [31:0] cycle_average(input logic [47:0] sum,
                                                  input logic [15:0] cnt);
      logic [47:0] q;
      q = 48'h0;
      if (cnt != 16'h0) begin
         q = sum / {32'h0, cnt};
      end
      return q[31:0];
   endfunction

   function automatic logic signed [31:0] to_power(
         input logic signed [15:0] cur, input logic [15:0] volt);
      logic signed [32:0] p;
      p = 33'(cur * $signed({1'b0, volt})) / 33'(POWER_SCALE);
      return p[31:0];
   endfunction

   load_mode_t load_mode;
   logic [2:0] load_select;
   logic signed [15:0] init_set;
   logic signed [15:0] init_clear;
   logic signed [15:0] final_set;
   logic signed [15:0] final_clear;
   logic signed [15:0] host_rate_value;
   logic signed [15:0] user_rate_current;
   logic signed [15:0] user_rate_power;
   logic signed [15:0] design_capacity;
   logic signed [15:0] design_energy;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic signed [31:0] passed_charge;
   logic signed [15:0] filtered_current;
   logic [31:0] tick_count;
   logic tick;
   logic discharging;
   logic [15:0] dsg_count;
   logic [47:0] dsg_current_sum;
   logic [47:0] dsg_power_sum;
   logic [31:0] prev_avg_current;
   logic [31:0] prev_avg_power;
   logic [15:0] dsg_magnitude;
   logic signed [31:0] dsg_power;
   logic [31:0] present_avg_current;
   logic [31:0] present_avg_power;
   logic signed [31:0] next_load_rate;
   logic signed [16:0] filter_diff;
   logic signed [16:0] filter_step;
   logic [3:0] flag_events;
   logic [3:0] irq_clear;
   logic [3:0] flag_clear;
   logic [DATA_W-1:0] read_value;

   assign dsg_magnitude = 16'(-average_current_value);
   assign dsg_power = to_power($signed(dsg_magnitude), voltage_value);
   assign present_avg_current = cycle_average(dsg_current_sum, dsg_count);
   assign present_avg_power = cycle_average(dsg_power_sum, dsg_count);
   assign filter_diff = 17'(average_current_value) - 17'(filtered_current);
   assign filter_step = filter_diff / 17'(FILTER_DIV);
   assign irq_clear = (wr && addr == REG_IRQ_STATUS) ? wdata[3:0] : 4'h0;
   assign flag_clear = (wr && addr == REG_FLAGS) ? wdata[3:0] : 4'h0;

   // update interval tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_count <= 32'h0;
         tick <= 1'b0;
      end else if (tick_count >= 32'(UPDATE_PERIOD - 1)) begin
         tick_count <= 32'h0;
         tick <= 1'b1;
      end else begin
         tick_count <= tick_count + 32'h1;
         tick <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         load_mode <= LOAD_CONSTANT_CURRENT;
         load_select <= SELECT_CURRENT_DEFAULT;
         init_set <= INIT_SET_RESET;
         init_clear <= INIT_CLEAR_RESET;
         final_set <= FINAL_SET_RESET;
         final_clear <= FINAL_CLEAR_RESET;
         host_rate_value <= 16'sh0000;
         user_rate_current <= 16'sh0000;
         user_rate_power <= 16'sh0000;
         design_capacity <= DESIGN_CAPACITY_RESET;
         design_energy <= DESIGN_ENERGY_RESET;
         irq_mask <= 4'h0;
      end else if (wr) begin
         if (addr == REG_LOAD_CONFIG) begin
            load_mode <= wdata[LOAD_MODE_POS] ? LOAD_CONSTANT_POWER
                                             : LOAD_CONSTANT_CURRENT;
            load_select <= wdata[LOAD_SELECT_LSB +: 3];
         end else if (addr == REG_INIT_SET) begin
            init_set <= wdata[15:0];
         end else if (addr == REG_INIT_CLEAR) begin
            init_clear <= wdata[15:0];
         end else if (addr == REG_FINAL_SET) begin
            final_set <= wdata[15:0];
         end else if (addr == REG_FINAL_CLEAR) begin
            final_clear <= wdata[15:0];
         end else if (addr == REG_HOST_RATE) begin
            host_rate_value <= wdata[15:0];
         end else if (addr == REG_USER_RATE_CURRENT) begin
            user_rate_current <= wdata[15:0];
         end else if (addr == REG_USER_RATE_POWER) begin
            user_rate_power <= wdata[15:0];
         end else if (addr == REG_DESIGN_CAPACITY) begin
            design_capacity <= wdata[15:0];
         end else if (addr == REG_DESIGN_ENERGY) begin
            design_energy <= wdata[15:0];
         end else if (addr == REG_IRQ_MASK) begin
            irq_mask <= wdata[3:0];
         end
      end
   end

   // capacity warning flags, evaluated once per update
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         initial_charge_warning_flag <= 1'b0;
         final_charge_warning_flag <= 1'b0;
      end else if (tick) begin
         if (!initial_charge_warning_flag &&
             remaining_capacity_value < init_set) begin
            initial_charge_warning_flag <= 1'b1;
         end else if (initial_charge_warning_flag &&
                      remaining_capacity_value > init_clear) begin
            initial_charge_warning_flag <= 1'b0;
         end
         if (!final_charge_warning_flag && final_set != THRESHOLD_OFF &&
             remaining_capacity_value < final_set) begin
            final_charge_warning_flag <= 1'b1;
         end else if (final_charge_warning_flag &&
                      remaining_capacity_value > final_clear) begin
            final_charge_warning_flag <= 1'b0;
         end
      end
   end

   // condition flags, detection wins over host clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         internal_short_flag <= 1'b0;
         tab_disconnect_flag <= 1'b0;
      end else begin
         if (short_detected) begin
            internal_short_flag <= 1'b1;
         end else if (flag_clear[BIT_SHORT]) begin
            internal_short_flag <= 1'b0;
         end
         if (tab_detected) begin
            tab_disconnect_flag <= 1'b1;
         end else if (flag_clear[BIT_TAB]) begin
            tab_disconnect_flag <= 1'b0;
         end
      end
   end

   // interrupt status, set wins over clear
   always_comb begin
      flag_events = 4'h0;
      flag_events[BIT_INITIAL] = tick && !initial_charge_warning_flag &&
                                 remaining_capacity_value < init_set;
      flag_events[BIT_FINAL] = tick && !final_charge_warning_flag &&
                               final_set != THRESHOLD_OFF &&
                               remaining_capacity_value < final_set;
      flag_events[BIT_SHORT] = short_detected && !internal_short_flag;
      flag_events[BIT_TAB] = tab_detected && !tab_disconnect_flag;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_status <= 4'h0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | flag_events;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_status & ~irq_clear) | flag_events) & irq_mask);
      end
   end

   // charge integration
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         passed_charge <= 32'sh0;
      end else if (charge_valid) begin
         passed_charge <= passed_charge + 32'(charge_delta);
      end
   end

   // low-pass filtered average current
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         filtered_current <= 16'sh0;
      end else if (tick) begin
         filtered_current <= filtered_current + filter_step[15:0];
      end
   end

   // discharge cycle averages of current and power
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         discharging <= 1'b0;
         dsg_count <= 16'h0;
         dsg_current_sum <= 48'h0;
         dsg_power_sum <= 48'h0;
         prev_avg_current <= 32'h0;
         prev_avg_power <= 32'h0;
      end else if (tick) begin
         discharging <= average_current_value < 16'sh0;
         if (average_current_value < 16'sh0) begin
            if (dsg_count != 16'hFFFF) begin
               dsg_count <= dsg_count + 16'h1;
               dsg_current_sum <= dsg_current_sum + 48'(dsg_magnitude);
               dsg_power_sum <= dsg_power_sum + 48'(dsg_power[31:0]);
            end
         end else if (discharging && dsg_count != 16'h0) begin
            prev_avg_current <= present_avg_current;
            prev_avg_power <= present_avg_power;
            dsg_count <= 16'h0;
            dsg_current_sum <= 48'h0;
            dsg_power_sum <= 48'h0;
         end
      end
   end

   // load model choice
   always_comb begin
      next_load_rate = 32'sh0;
      if (load_mode == LOAD_CONSTANT_CURRENT) begin
         case (load_select)
            3'h0: next_load_rate = $signed(prev_avg_current);
            3'h2: next_load_rate = 32'(average_current_value);
            3'h3: next_load_rate = 32'(filtered_current);
            3'h4: next_load_rate = 32'(design_capacity / 16'(C_RATE_DIV));
            3'h5: next_load_rate = 32'(host_rate_value);
            3'h6: next_load_rate = 32'(user_rate_current);
            default: next_load_rate = $signed(present_avg_current);
         endcase
      end else begin
         case (load_select)
            3'h1: next_load_rate = $signed(present_avg_power);
            3'h2: begin
               next_load_rate = to_power(average_current_value,
                                         voltage_value);
            end
            3'h3: begin
               next_load_rate = to_power(filtered_current,
                                         voltage_value);
            end
            3'h4: next_load_rate = 32'(design_energy / 16'(C_RATE_DIV));
            3'h5: next_load_rate = 32'(host_rate_value);
            3'h6: next_load_rate = 32'(user_rate_power);
            default: next_load_rate = $signed(prev_avg_power);
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         load_rate_value <= 32'sh0;
         load_mode_status_bit <= LOAD_MODE_RESET;
      end else begin
         load_rate_value <= next_load_rate;
         load_mode_status_bit <= load_mode == LOAD_CONSTANT_POWER;
      end
   end

   // read decode
   always_comb begin
      read_value = 32'h0;
      if (addr == REG_FLAGS) begin
         read_value[BIT_INITIAL] = initial_charge_warning_flag;
         read_value[BIT_FINAL] = final_charge_warning_flag;
         read_value[BIT_SHORT] = internal_short_flag;
         read_value[BIT_TAB] = tab_disconnect_flag;
      end else if (addr == REG_CONTROL_STATUS) begin
         read_value[BIT_LOAD_MODE] = load_mode == LOAD_CONSTANT_POWER;
      end else if (addr == REG_LOAD_CONFIG) begin
         read_value[LOAD_MODE_POS] = load_mode == LOAD_CONSTANT_POWER;
         read_value[LOAD_SELECT_LSB +: 3] = load_select;
      end else if (addr == REG_INIT_SET) begin
         read_value[15:0] = init_set;
      end else if (addr == REG_INIT_CLEAR) begin
         read_value[15:0] = init_clear;
      end else if (addr == REG_FINAL_SET) begin
         read_value[15:0] = final_set;
      end else if (addr == REG_FINAL_CLEAR) begin
         read_value[15:0] = final_clear;
      end else if (addr == REG_HOST_RATE) begin
         read_value[15:0] = host_rate_value;
      end else if (addr == REG_USER_RATE_CURRENT) begin
         read_value[15:0] = user_rate_current;
      end else if (addr == REG_USER_RATE_POWER) begin
         read_value[15:0] = user_rate_power;
      end else if (addr == REG_DESIGN_CAPACITY) begin
         read_value[15:0] = design_capacity;
      end else if (addr == REG_DESIGN_ENERGY) begin
         read_value[15:0] = design_energy;
      end else if (addr == REG_IRQ_STATUS) begin
         read_value[3:0] = irq_status;
      end else if (addr == REG_IRQ_MASK) begin
         read_value[3:0] = irq_mask;
      end else if (addr == REG_LOAD_RATE) begin
         read_value = load_rate_value;
      end else if (addr == REG_PASSED_CHARGE) begin
         read_value = passed_charge;
      end else if (addr == REG_FILTERED_CURRENT) begin
         read_value[15:0] = filtered_current;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0;
      end else if (rd) begin
         rdata <= read_value;
      end else begin
         rdata <= 32'h0;
      end
   end

endmodule

// ===== rtl/gauge_flags_pkg.sv
// constants and register map of the gauge flag and load model block
package gauge_flags_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // register offsets
   localparam logic [7:0] REG_FLAGS = 8'h00;
   localparam logic [7:0] REG_CONTROL_STATUS = 8'h01;
   localparam logic [7:0] REG_LOAD_CONFIG = 8'h02;
   localparam logic [7:0] REG_INIT_SET = 8'h03;
   localparam logic [7:0] REG_INIT_CLEAR = 8'h04;
   localparam logic [7:0] REG_FINAL_SET = 8'h05;
   localparam logic [7:0] REG_FINAL_CLEAR = 8'h06;
   localparam logic [7:0] REG_HOST_RATE = 8'h07;
   localparam logic [7:0] REG_USER_RATE_CURRENT = 8'h08;
   localparam logic [7:0] REG_USER_RATE_POWER = 8'h09;
   localparam logic [7:0] REG_DESIGN_CAPACITY = 8'h0A;
   localparam logic [7:0] REG_DESIGN_ENERGY = 8'h0B;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0D;
   localparam logic [7:0] REG_LOAD_RATE = 8'h0E;
   localparam logic [7:0] REG_PASSED_CHARGE = 8'h0F;
   localparam logic [7:0] REG_FILTERED_CURRENT = 8'h10;
   // flag and event bit positions
   localparam int BIT_INITIAL = 0;
   localparam int BIT_FINAL = 1;
   localparam int BIT_SHORT = 2;
   localparam int BIT_TAB = 3;
   localparam int BIT_LOAD_MODE = 0;
   localparam int LOAD_MODE_POS = 4;
   localparam int LOAD_SELECT_LSB = 0;
   // values after reset
   localparam logic LOAD_MODE_RESET = 1'b0;
   localparam logic [2:0] SELECT_CURRENT_DEFAULT = 3'h1;
   localparam logic [2:0] SELECT_POWER_DEFAULT = 3'h0;
   localparam logic signed [15:0] INIT_SET_RESET = 16'sh0096;
   localparam logic signed [15:0] INIT_CLEAR_RESET = 16'sh00AF;
   localparam logic signed [15:0] FINAL_SET_RESET = 16'sh004B;
   localparam logic signed [15:0] FINAL_CLEAR_RESET = 16'sh0064;
   localparam logic signed [15:0] THRESHOLD_OFF = 16'shFFFF;
   localparam logic signed [15:0] DESIGN_CAPACITY_RESET = 16'sh03E8;
   localparam logic signed [15:0] DESIGN_ENERGY_RESET = 16'sh0E74;
   // timing
   localparam int CLK_KHZ = 100000;
   localparam int UPDATE_TIME_MS = 1000;
   localparam int UPDATE_CYCLES = UPDATE_TIME_MS * CLK_KHZ / 1000;
   localparam int FILTER_TAU_S = 14;
   localparam int FILTER_DIV = FILTER_TAU_S * 1000 / UPDATE_TIME_MS;
   localparam int C_RATE_DIV = 5;
   localparam int POWER_SCALE = 1000;
   typedef enum logic [1:0] {
      LOAD_CONSTANT_CURRENT = 2'b01,
      LOAD_CONSTANT_POWER = 2'b10
   } load_mode_t;
endpackage

// ===== test/gauge_flags_checker.sv
// concurrent checks on the gauge flag block ports
`timescale 1ns/1ps
module gauge_flags_checker
   import gauge_flags_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic signed [15:0] remaining_capacity_value,
   input wire logic short_detected,
   input wire logic tab_detected,
   input wire logic initial_charge_warning_flag,
   input wire logic final_charge_warning_flag,
   input wire logic internal_short_flag,
   input wire logic tab_disconnect_flag,
   input wire logic load_mode_status_bit,
   input wire logic irq
);
   logic signed [15:0] final_set;

   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   // shadow of the final warning set level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         final_set <= FINAL_SET_RESET;
      end else if (wr && addr == REG_FINAL_SET) begin
         final_set <= $signed(wdata[15:0]);
      end
   end

   chk_read_idle_zero: assert property (
      !$past(rd) |-> rdata == '0) else $error("read data not zero");
   chk_short_sets_flag: assert property (
      short_detected |=> internal_short_flag)
      else $error("short flag not set");
   chk_tab_sets_flag: assert property (
      tab_detected |=> tab_disconnect_flag)
      else $error("tab flag not set");
   chk_mode_follows_write: assert property (
      (wr && addr == REG_LOAD_CONFIG) |-> ##2
      (load_mode_status_bit == $past(wdata[LOAD_MODE_POS], 2)))
      else $error("load mode bit wrong");
   chk_initial_set_level: assert property (
      $rose(initial_charge_warning_flag) |->
      $past(remaining_capacity_value) < INIT_SET_RESET)
      else $error("initial warning set above level");
   chk_initial_clear_level: assert property (
      $fell(initial_charge_warning_flag) |->
      $past(remaining_capacity_value) > INIT_CLEAR_RESET)
      else $error("initial warning cleared below level");
   chk_final_set_level: assert property (
      $rose(final_charge_warning_flag) |->
      $past(remaining_capacity_value) < $past(final_set))
      else $error("final warning set above level");
   chk_final_off_level: assert property (
      $rose(final_charge_warning_flag) |-> $past(final_set) != THRESHOLD_OFF)
      else $error("final warning set while disabled");
   chk_final_clear_level: assert property (
      $fell(final_charge_warning_flag) |->
      $past(remaining_capacity_value) > FINAL_CLEAR_RESET)
      else $error("final warning cleared below level");

   cover property ($rose(initial_charge_warning_flag));
   cover property ($fell(final_charge_warning_flag));
   cover property ($rose(irq));
   cover property ($rose(load_mode_status_bit));
endmodule

// ===== test/gauge_flags_tb_top.sv
// self-checking bench for the gauge flag and load model block
`timescale 1ns/1ps
module gauge_flags_tb_top
   import gauge_flags_pkg::*;
   ;
   localparam int PERIOD = 16;
   localparam logic [31:0] RESET_EXP [10] = '{32'h1, 32'h96, 32'hAF,
      32'h4B, 32'h64, 32'h0, 32'h0, 32'h0, 32'h3E8, 32'hE74};
   localparam logic signed [15:0] CAPS [9] = '{16'shA0, 16'sh8C, 16'shA0,
      16'shB4, 16'sh32, 16'sh5A, 16'sh6E, 16'sh0, 16'sh3E8};
   localparam logic [1:0] FEXP [9] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h3, 2'h3,
      2'h1, 2'h1, 2'h0};
   localparam logic SM [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
   localparam logic [2:0] SC [8] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h2, 3'h4,
      3'h5, 3'h6};
   localparam logic [31:0] SE [8] = '{32'h12C, 32'hC8, 32'h123, 32'h45,
      32'h5DC, 32'h2E4, 32'h123, 32'h67};
   logic clk;
   logic rst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [DATA_W-1:0] rdata;
   logic signed [15:0] cap;
   logic signed [15:0] avg;
   logic [15:0] volt;
   logic short_det;
   logic tab_det;
   logic chg_valid;
   logic signed [15:0] chg_delta;
   logic init_flag;
   logic final_flag;
   logic short_flag;
   logic tab_flag;
   logic mode_bit;
   logic signed [31:0] rate;
   logic irq;
   int num_errors;
   int checked;
   int cycles;

   gauge_flags #(.UPDATE_PERIOD(PERIOD)) i_dut (.clk(clk), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .remaining_capacity_value(cap), .average_current_value(avg),
      .voltage_value(volt), .short_detected(short_det),
      .tab_detected(tab_det), .charge_valid(chg_valid),
      .charge_delta(chg_delta), .initial_charge_warning_flag(init_flag),
      .final_charge_warning_flag(final_flag),
      .internal_short_flag(short_flag), .tab_disconnect_flag(tab_flag),
      .load_mode_status_bit(mode_bit), .load_rate_value(rate), .irq(irq));

   gauge_host_model i_host (.clk(clk), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic results();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      i_host.read_reg(a, d);
      check(d, e);
   endtask

   task automatic wt(input int n);
      repeat (n * PERIOD + 2) @(posedge clk);
   endtask

   task automatic sel(input logic m, input logic [2:0] c, input logic [31:0] e);
      i_host.write_reg(REG_LOAD_CONFIG, {27'h0, m, 1'b0, c});
      repeat (3) @(posedge clk);
      #1;
      check(rate, e);
      check({31'h0, mode_bit}, {31'h0, m});
   endtask

   initial begin
      rst = 1'b1;
      cap = 16'sh3E8;
      avg = 16'sh12C;
      volt = 16'h1388;
      short_det = 1'b0;
      tab_det = 1'b0;
      chg_valid = 1'b0;
      chg_delta = 16'sh0;
      num_errors = 0;
      checked = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         rchk(8'h02 + 8'(i), RESET_EXP[i]);
      end
      i_host.write_reg(8'h20, 32'h5A);
      rchk(8'h20, 32'h0);
      // two separated charge deltas, +7 then -2
      @(posedge clk);
      chg_valid <= 1'b1;
      chg_delta <= 16'sh7;
      @(posedge clk);
      chg_valid <= 1'b0;
      @(posedge clk);
      chg_valid <= 1'b1;
      chg_delta <= 16'shFFFE;
      @(posedge clk);
      chg_valid <= 1'b0;
      rchk(REG_PASSED_CHARGE, 32'h5);
      // capacity steps through both hysteresis bands
      for (int i = 0; i < 9; i++) begin
         if (i == 7) begin
            i_host.write_reg(REG_FINAL_SET, 32'h0000FFFF);
         end
         @(posedge clk);
         cap <= CAPS[i];
         wt(2);
         #1;
         check({31'h0, init_flag}, {31'h0, FEXP[i][0]});
         check({31'h0, final_flag}, {31'h0, FEXP[i][1]});
         rchk(REG_FLAGS, {30'h0, FEXP[i]});
      end
      rchk(REG_IRQ_STATUS, 32'h3);
      #1;
      check({31'h0, irq}, 32'h0);
      i_host.write_reg(REG_IRQ_STATUS, 32'hF);
      i_host.write_reg(REG_IRQ_MASK, 32'h4);
      rchk(REG_IRQ_STATUS, 32'h0);
      // condition flags and interrupt
      @(posedge clk);
      short_det <= 1'b1;
      @(posedge clk);
      short_det <= 1'b0;
      tab_det <= 1'b1;
      @(posedge clk);
      tab_det <= 1'b0;
      @(posedge clk);
      #1;
      check({31'h0, short_flag}, 32'h1);
      check({31'h0, tab_flag}, 32'h1);
      check({31'h0, irq}, 32'h1);
      i_host.write_reg(REG_IRQ_STATUS, 32'h4);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, irq}, 32'h0);
      rchk(REG_IRQ_STATUS, 32'h8);
      rchk(REG_FLAGS, 32'hC);
      i_host.write_reg(REG_FLAGS, 32'hC);
      rchk(REG_FLAGS, 32'h0);
      // load model choices
      i_host.write_reg(REG_HOST_RATE, 32'h123);
      i_host.write_reg(REG_USER_RATE_CURRENT, 32'h45);
      i_host.write_reg(REG_USER_RATE_POWER, 32'h67);
      for (int i = 0; i < 8; i++) begin
         sel(SM[i], SC[i], SE[i]);
      end
      // filter settles at 287 with a constant 300 and step (d)/14
      wt(40);
      rchk(REG_FILTERED_CURRENT, 32'h11F);
      sel(1'b0, 3'h3, 32'h11F);
      sel(1'b1, 3'h3, 32'h59B);
      i_host.write_reg(REG_LOAD_CONFIG, 32'h13);
      i_host.write_reg(REG_LOAD_CONFIG, 32'h3);
      @(posedge clk);
      avg <= 16'shFF9C;
      wt(3);
      sel(1'b0, 3'h0, 32'h0);
      sel(1'b0, 3'h1, 32'h64);
      sel(1'b0, 3'h7, 32'h64);
      sel(1'b1, 3'h1, 32'h1F4);
      @(posedge clk);
      avg <= 16'sh12C;
      wt(2);
      sel(1'b0, 3'h0, 32'h64);
      sel(1'b1, 3'h0, 32'h1F4);
      sel(1'b1, 3'h7, 32'h1F4);
      rchk(REG_CONTROL_STATUS, 32'h1);
      results();
   end
endmodule

bind gauge_flags gauge_flags_checker i_chk (.clk(clk), .rst(rst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .remaining_capacity_value(remaining_capacity_value),
   .short_detected(short_detected), .tab_detected(tab_detected),
   .initial_charge_warning_flag(initial_charge_warning_flag),
   .final_charge_warning_flag(final_charge_warning_flag),
   .internal_short_flag(internal_short_flag),
   .tab_disconnect_flag(tab_disconnect_flag),
   .load_mode_status_bit(load_mode_status_bit), .irq(irq));

// ===== test/gauge_host_model.sv
// host side model driving the register port
`timescale 1ns/1ps
module gauge_host_model
   import gauge_flags_pkg::*;
(
   input wire logic clk,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [DATA_W-1:0] rdata
);
   initial begin
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
   end

   // released lines show the inverse, never the last value
   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      @(posedge clk);
      d = rdata;
   endtask
endmodule
